// ===== dfds_map.svh
/*
  Register map, field positions, reset values and timing figures of the
  dual fan driver status block. Definitions only.
  Assumes it is included by its bare name before any module that uses it.
*/
`ifndef DFDS_MAP_SVH
`define DFDS_MAP_SVH

// ==========================================================
// Register indices; byte address is four times the index
`define DFDS_STATUS_IDX 8'h37
`define DFDS_CTRL_IDX 8'h70
`define DFDS_SHORT_IDX 8'h71
`define DFDS_MASK_IDX 8'h72

// ==========================================================
// Status register fields
`define DFDS_ST_FAIL2 7
`define DFDS_ST_FAIL1 6
`define DFDS_ST_WATCH 5
`define DFDS_ST_SPARE 4
`define DFDS_ST_GOOD2 3
`define DFDS_ST_LOW2 2
`define DFDS_ST_GOOD1 1
`define DFDS_ST_LOW1 0

// ==========================================================
// Control register fields
`define DFDS_CT_EN1 0
`define DFDS_CT_EN2 1
`define DFDS_CT_REG2 2
`define DFDS_CT_GIE 7
`define DFDS_CTRL_WMASK 8'h87

// ==========================================================
// Mask register fields (short bits also the short register layout)
`define DFDS_MK_SHORT1 0
`define DFDS_MK_SHORT2 1
`define DFDS_MASK_WMASK 8'hC3

// ==========================================================
// Reset values
`define DFDS_STATUS_RST 8'h00
`define DFDS_CTRL_RST 8'h00
`define DFDS_SHORT_RST 2'h0
`define DFDS_MASK_RST 8'h00

// ==========================================================
// Timing
`define DFDS_CLK_KHZ 200000
`define DFDS_WDT_TIMEOUT_MS 6000

`endif

// ===== dfds_pkg.sv
/*
  Types shared by the dual fan driver status block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none

package dfds_pkg;

  // ==========================================================
  // Bus handshake states, one-hot
  typedef enum logic [1:0] {
    DFDS_IDLE = 2'b01,
    DFDS_ACK = 2'b10
  } dfds_bus_state_t;

  // ==========================================================
  // Data types
  typedef logic [31:0] dfds_word_t;
  typedef logic [7:0] dfds_byte_t;

endpackage

`default_nettype wire

// ===== dfds_status.sv
/*
  Dual fan driver status register bank with watchdog and alert output.
  Assumes an Avalon-MM master on ref_clk and analog condition levels that
  arrive asynchronously and are synchronised here.
*/
// How it works
// - Status-register flags of a disabled driver read zero.
// - Fan-two drive-failure flag, bit 7, follows the unreachable-target condition.
// - Fan-one drive-failure flag, bit 6, follows the unreachable-target condition.
// - Drive-failure flags latch; a read clears them only once the fault is gone.
// - A set and enabled drive-failure flag pulls the alert output low.
// - Watchdog full count of six seconds sets bit 5 and forces full fan drive.
// - Any data write disables the watchdog, so no timeout follows.
// - Watchdog flag has no mask; only the global enable gates it.
// - Reading the status register clears the watchdog flag only if that read saw it set.
// - Voltage-good bits 3 and 1 read one only while output matches target.
// - A short clears voltage-good and raises the matching fan-short flag.
// - Low-supply bits 2 and 0 show which pass device feeds the fan.
// - Driver-two low-supply bit reads zero in regulator mode.
// - Alert is low while an enabled flag is set and global enable is one.
`timescale 1ns/1ps
`default_nettype none
`include "dfds_map.svh"

module dfds_status #(
  parameter int ADDR_W = 10,
  parameter int unsigned WDT_CYCLES = 32'(64'd`DFDS_WDT_TIMEOUT_MS * 64'd`DFDS_CLK_KHZ)
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output dfds_pkg::dfds_word_t readdata,
  output logic waitrequest,
  input wire logic [1:0] fan_unreachable,
  input wire logic [1:0] voltage_match,
  input wire logic [1:0] output_short,
  input wire logic [1:0] low_supply_on,
  output logic fans_full_drive,
  output logic alert_interrupt_n
);
  import dfds_pkg::*;

  // ==========================================================
  // Declarations
  dfds_bus_state_t state_q;
  dfds_word_t rdata_q;
  dfds_byte_t ctrl_q;
  dfds_byte_t mask_q;
  dfds_byte_t status_w;
  dfds_byte_t rd_snap_q;
  dfds_byte_t rd_mux;
  logic [1:0] fail_q;
  logic [1:0] short_q;
  logic watch_q;
  logic [31:0] wdt_cnt_q;
  logic wdt_off_q;
  logic wdt_fire;
  logic full_q;
  logic alert_n_q;
  logic [7:0] sync_w;
  logic [1:0] unreach_s;
  logic [1:0] match_s;
  logic [1:0] short_s;
  logic [1:0] low_s;
  logic [1:0] drv_en;
  logic [ADDR_W-3:0] idx;
  logic acc_rd;
  logic acc_wr;
  logic wr_lane0;
  logic rd_status;
  logic irq_any;

  // ==========================================================
  // Analog condition levels cross into ref_clk here
  dfds_sync #(
    .WIDTH(8)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .ce(ce),
    .async_in({low_supply_on, output_short, voltage_match, fan_unreachable}),
    .sync_out(sync_w)
  );

  assign unreach_s = sync_w[1:0];
  assign match_s = sync_w[3:2];
  assign short_s = sync_w[5:4];
  assign low_s = sync_w[7:6];
  assign drv_en = {ctrl_q[`DFDS_CT_EN2], ctrl_q[`DFDS_CT_EN1]};

  // ==========================================================
  // Bus handshake: one wait cycle, access takes effect in ACK
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= DFDS_IDLE;
    end else if (ce) begin
      case (state_q)
        DFDS_IDLE: begin
          if (read || write) begin
            state_q <= DFDS_ACK;
          end
        end
        DFDS_ACK: begin
          state_q <= DFDS_IDLE;
        end
        default: begin
          state_q <= DFDS_IDLE;
        end
      endcase
    end
  end

  // Frozen clock enable keeps the master waiting
  assign waitrequest = (read || write) && !(state_q == DFDS_ACK && ce);
  assign acc_rd = ce && state_q == DFDS_ACK && read;
  assign acc_wr = ce && state_q == DFDS_ACK && write;
  assign wr_lane0 = acc_wr && byteenable[0];
  assign idx = address[ADDR_W-1:2];
  assign rd_status = acc_rd && idx == (ADDR_W-2)'(`DFDS_STATUS_IDX);

  // ==========================================================
  // Status view assembled from live levels and sticky flags
  always_comb begin
    status_w = `DFDS_STATUS_RST;
    status_w[`DFDS_ST_FAIL2] = drv_en[1] && fail_q[1];
    status_w[`DFDS_ST_FAIL1] = drv_en[0] && fail_q[0];
    status_w[`DFDS_ST_WATCH] = watch_q;
    status_w[`DFDS_ST_SPARE] = 1'b0;
    status_w[`DFDS_ST_GOOD2] = drv_en[1] && match_s[1] && !short_s[1];
    status_w[`DFDS_ST_GOOD1] = drv_en[0] && match_s[0] && !short_s[0];
    status_w[`DFDS_ST_LOW2] = drv_en[1] && low_s[1] && !ctrl_q[`DFDS_CT_REG2];
    status_w[`DFDS_ST_LOW1] = drv_en[0] && low_s[0];
  end

  // ==========================================================
  // Read mux; unmapped words read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (idx == (ADDR_W-2)'(`DFDS_STATUS_IDX)) begin
      rd_mux = status_w;
    end else if (idx == (ADDR_W-2)'(`DFDS_CTRL_IDX)) begin
      rd_mux = ctrl_q;
    end else if (idx == (ADDR_W-2)'(`DFDS_SHORT_IDX)) begin
      rd_mux = {6'h00, short_q};
    end else if (idx == (ADDR_W-2)'(`DFDS_MASK_IDX)) begin
      rd_mux = mask_q;
    end
  end

  // Captured on entry to ACK; snapshot decides what a read may clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
      rd_snap_q <= 8'h00;
    end else if (ce && state_q == DFDS_IDLE && read) begin
      rdata_q <= {24'h00_0000, rd_mux};
      rd_snap_q <= status_w;
    end
  end

  assign readdata = rdata_q;

  // ==========================================================
  // Control and mask registers; the status word has no write path
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q <= `DFDS_CTRL_RST;
      mask_q <= `DFDS_MASK_RST;
    end else if (wr_lane0) begin
      if (idx == (ADDR_W-2)'(`DFDS_CTRL_IDX)) begin
        ctrl_q <= writedata[7:0] & `DFDS_CTRL_WMASK;
      end else if (idx == (ADDR_W-2)'(`DFDS_MASK_IDX)) begin
        mask_q <= writedata[7:0] & `DFDS_MASK_WMASK;
      end
    end
  end

  // ==========================================================
  // Per-driver sticky flags
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_drv
      // Drive failure: set while unreachable, read clears only a seen, gone fault
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          fail_q[gi] <= 1'b0;
        end else if (ce) begin
          if (!drv_en[gi]) begin
            fail_q[gi] <= 1'b0;
          end else if (unreach_s[gi]) begin
            fail_q[gi] <= 1'b1;
          end else if (rd_status && rd_snap_q[`DFDS_ST_FAIL1 + gi]) begin
            fail_q[gi] <= 1'b0;
          end
        end
      end

      // Short flag: set wins over a write-one clear
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          short_q[gi] <= 1'b0;
        end else if (ce) begin
          if (drv_en[gi] && short_s[gi]) begin
            short_q[gi] <= 1'b1;
          end else if (wr_lane0 && idx == (ADDR_W-2)'(`DFDS_SHORT_IDX) && writedata[gi]) begin
            short_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Watchdog: counts from reset until the first data write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdt_off_q <= 1'b0;
    end else if (acc_wr) begin
      wdt_off_q <= 1'b1;
    end
  end

  // Saturates at the full count so the timeout fires once
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdt_cnt_q <= 32'h0000_0000;
    end else if (ce && !wdt_off_q && !acc_wr && wdt_cnt_q != WDT_CYCLES) begin
      wdt_cnt_q <= wdt_cnt_q + 32'h0000_0001;
    end
  end

  assign wdt_fire = ce && !wdt_off_q && !acc_wr && wdt_cnt_q == WDT_CYCLES - 32'd1;

  // Full drive holds until software takes over with a write
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      full_q <= 1'b0;
    end else if (wdt_fire) begin
      full_q <= 1'b1;
    end else if (acc_wr) begin
      full_q <= 1'b0;
    end
  end

  assign fans_full_drive = full_q;

  // Timeout flag; a new timeout wins over the read clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      watch_q <= 1'b0;
    end else if (wdt_fire) begin
      watch_q <= 1'b1;
    end else if (rd_status && rd_snap_q[`DFDS_ST_WATCH]) begin
      watch_q <= 1'b0;
    end
  end

  // ==========================================================
  // Alert: registered so the pin never glitches
  assign irq_any = (fail_q[1] && mask_q[`DFDS_ST_FAIL2]) || (fail_q[0] && mask_q[`DFDS_ST_FAIL1])
    || watch_q
    || |(short_q & mask_q[1:0]);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      alert_n_q <= 1'b1;
    end else if (ce) begin
      alert_n_q <= !(ctrl_q[`DFDS_CT_GIE] && irq_any);
    end
  end

  assign alert_interrupt_n = alert_n_q;

  // ==========================================================
  // Checks
  property p_disabled_zero;
    @(posedge ref_clk) disable iff (srst)
    (ce && !drv_en[0]) |-> (status_w[`DFDS_ST_FAIL1] == 1'b0 && status_w[1:0] == 2'b00) ##1 !fail_q[0];
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("disabled driver shows a flag");

  property p_fail2_set;
    @(posedge ref_clk) disable iff (srst)
    (ce && drv_en[1] && unreach_s[1] && !wr_lane0) |=> status_w[`DFDS_ST_FAIL2];
  endproperty
  a_fail2_set: assert property (p_fail2_set) else $error("fan two failure not flagged");

  property p_fail1_set;
    @(posedge ref_clk) disable iff (srst)
    (ce && drv_en[0] && unreach_s[0] && !wr_lane0) |=> status_w[`DFDS_ST_FAIL1];
  endproperty
  a_fail1_set: assert property (p_fail1_set) else $error("fan one failure not flagged");

  property p_fail_sticky;
    @(posedge ref_clk) disable iff (srst)
    (ce && fail_q[0] && drv_en[0] && !rd_status && !wr_lane0) |=> fail_q[0];
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("failure flag dropped without read");

  property p_fail_alert;
    @(posedge ref_clk) disable iff (srst)
    (ce && ctrl_q[`DFDS_CT_GIE] && fail_q[1] && mask_q[`DFDS_ST_FAIL2]) |=> !alert_interrupt_n;
  endproperty
  a_fail_alert: assert property (p_fail_alert) else $error("enabled failure gave no alert");

  property p_wdt_fire;
    @(posedge ref_clk) disable iff (srst)
    wdt_fire |=> (watch_q && fans_full_drive);
  endproperty
  a_wdt_fire: assert property (p_wdt_fire) else $error("timeout did not flag and force fans");

  property p_wdt_off;
    @(posedge ref_clk) disable iff (srst)
    acc_wr |=> (wdt_off_q && !wdt_fire) [*3];
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("watchdog alive after a write");

  property p_watch_alert;
    @(posedge ref_clk) disable iff (srst)
    (ce && ctrl_q[`DFDS_CT_GIE] && watch_q) |=> !alert_interrupt_n;
  endproperty
  a_watch_alert: assert property (p_watch_alert) else $error("timeout flag was masked");

  property p_watch_clear;
    @(posedge ref_clk) disable iff (srst)
    (rd_status && rd_snap_q[`DFDS_ST_WATCH] && !wdt_fire) |=> !watch_q;
  endproperty
  a_watch_clear: assert property (p_watch_clear) else $error("read left timeout flag set");

  property p_good_bits;
    @(posedge ref_clk) disable iff (srst)
    status_w[`DFDS_ST_GOOD2] |-> (drv_en[1] && match_s[1] && !short_s[1]);
  endproperty
  a_good_bits: assert property (p_good_bits) else $error("voltage-good without match");

  property p_short;
    @(posedge ref_clk) disable iff (srst)
    (ce && drv_en[0] && short_s[0]) |-> (!status_w[`DFDS_ST_GOOD1] ##1 short_q[0]);
  endproperty
  a_short: assert property (p_short) else $error("short not reported");

  property p_low1;
    @(posedge ref_clk) disable iff (srst)
    status_w[`DFDS_ST_LOW1] == (drv_en[0] && low_s[0]);
  endproperty
  a_low1: assert property (p_low1) else $error("pass device bit wrong");

  property p_reg_mode;
    @(posedge ref_clk) disable iff (srst)
    ctrl_q[`DFDS_CT_REG2] |-> !status_w[`DFDS_ST_LOW2];
  endproperty
  a_reg_mode: assert property (p_reg_mode) else $error("pass bit set in regulator mode");

  property p_release;
    @(posedge ref_clk) disable iff (srst)
    (ce && !irq_any) |=> alert_interrupt_n;
  endproperty
  a_release: assert property (p_release) else $error("alert held with no flag");

  property p_spare;
    @(posedge ref_clk) disable iff (srst)
    !status_w[`DFDS_ST_SPARE];
  endproperty
  a_spare: assert property (p_spare) else $error("spare bit nonzero");

endmodule

`default_nettype wire

// ===== dfds_sync.sv
/*
  Two-stage synchroniser for a group of level inputs from the analog side.
  Assumes the inputs are slow levels; no pulse shorter than a few clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module dfds_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // ==========================================================
  // First stage is read only by the second stage
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ===== test_dfds_status.sv
/*
  Self-checking bench for the dual fan driver status register bank.
  Assumes the design files and dfds_map.svh are compiled first; the bench
  drives every port itself and shortens the watchdog count to WDT cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dfds_map.svh"

module test_dfds_status;
  import dfds_pkg::*;

  // ==========================================================
  // Constants and signals
  localparam int WDT = 50;
  localparam logic [9:0] A_ST = {`DFDS_STATUS_IDX, 2'h0};
  localparam logic [9:0] A_CT = {`DFDS_CTRL_IDX, 2'h0};
  localparam logic [9:0] A_SH = {`DFDS_SHORT_IDX, 2'h0};
  localparam logic [9:0] A_MK = {`DFDS_MASK_IDX, 2'h0};
  localparam logic [9:0] A_NONE = 10'h3FC;
  logic ref_clk, srst, ce, read, write, waitrequest, fans_full_drive, alert_interrupt_n;
  logic [9:0] address;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  dfds_word_t readdata;
  logic [1:0] fan_unreachable, voltage_match, output_short, low_supply_on;
  int num_errors, cmp_count, seed;
  logic rnd_ce;
  logic [7:0] rv;
  logic [31:0] exp_q[$];

  dfds_status #(.ADDR_W(10), .WDT_CYCLES(WDT)) dfds_status_i (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .fan_unreachable(fan_unreachable), .voltage_match(voltage_match), .output_short(output_short),
    .low_supply_on(low_supply_on), .fans_full_drive(fans_full_drive),
    .alert_interrupt_n(alert_interrupt_n)
  );

  // ==========================================================
  // Clock, and a clock enable that stalls the bus when asked
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    ce <= rnd_ce ? (($random(seed) & 3) != 0) : 1'b1;
  end

  // ==========================================================
  // Comparison and closing
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic is_wr, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    read <= !is_wr;
    write <= is_wr;
    address <= a;
    writedata <= {24'($random(seed)), d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 200);
    if (n >= 200) check(32'(waitrequest), 32'h0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // Expected read data goes on the queue; the monitor compares it
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    bus(1'b0, a, 8'h00);
  endtask

  // Synchronisers freeze while ce is low, so allow slack
  task automatic settle();
    repeat (30) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // ==========================================================
  // Read monitor: data taken at the edge that ends the ACK cycle
  always @(posedge ref_clk) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check(readdata, 32'hFFFFFFFF);
      else check(readdata, exp_q.pop_front());
    end
  end

  // ==========================================================
  // Watchdog: generous margin over the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 23202;
    rnd_ce = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    srst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    writedata = 32'h0;
    byteenable = 4'hF;
    fan_unreachable = 2'h0;
    voltage_match = 2'h3;
    output_short = 2'h0;
    low_supply_on = 2'h3;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    // Watchdog expires with no write; drivers are still disabled
    repeat (WDT + 20) @(posedge ref_clk);
    @(negedge ref_clk);
    check(32'(fans_full_drive), 32'h1);
    check(32'(alert_interrupt_n), 32'h1);
    wr(A_CT, 8'h80);
    settle();
    check(32'(fans_full_drive), 32'h0);
    check(32'(alert_interrupt_n), 32'h0);
    rd(A_ST, 8'h20);
    settle();
    check(32'(alert_interrupt_n), 32'h1);
    rd(A_ST, 8'h00);
    repeat (WDT + 20) @(posedge ref_clk);
    @(negedge ref_clk);
    check(32'(fans_full_drive), 32'h0);
    rd(A_ST, 8'h00);
    // Reset values, unmapped place, status write ignored, with bus stalls
    rnd_ce <= 1'b1;
    rd(A_MK, 8'h00);
    rd(A_SH, 8'h00);
    rd(A_NONE, 8'h00);
    wr(A_NONE, 8'hFF);
    wr(A_ST, 8'hFF);
    rd(A_ST, 8'h00);
    wr(A_CT, 8'hFF);
    rd(A_CT, 8'h87);
    // Lane 0 disabled: the write must not land
    byteenable <= 4'hE;
    wr(A_CT, 8'h00);
    byteenable <= 4'hF;
    rd(A_CT, 8'h87);
    for (int i = 0; i < 4; i++) begin
      rv = 8'($random(seed));
      wr(A_MK, rv);
      rd(A_MK, rv & `DFDS_MASK_WMASK);
    end
    // Voltage-good and pass-device bits per driver
    wr(A_MK, 8'h00);
    wr(A_CT, 8'h83);
    settle();
    rd(A_ST, 8'h0F);
    voltage_match <= 2'h1;
    low_supply_on <= 2'h2;
    settle();
    rd(A_ST, 8'h06);
    voltage_match <= 2'h2;
    low_supply_on <= 2'h1;
    settle();
    rd(A_ST, 8'h09);
    voltage_match <= 2'h3;
    low_supply_on <= 2'h3;
    wr(A_CT, 8'h87);
    settle();
    rd(A_ST, 8'h0B);
    // Fan two failure, enabled: latches, alerts, clears after it goes
    voltage_match <= 2'h0;
    low_supply_on <= 2'h0;
    wr(A_CT, 8'h83);
    wr(A_MK, 8'h80);
    fan_unreachable <= 2'h2;
    settle();
    check(32'(alert_interrupt_n), 32'h0);
    rd(A_ST, 8'h80);
    rd(A_ST, 8'h80);
    fan_unreachable <= 2'h0;
    settle();
    rd(A_ST, 8'h80);
    rd(A_ST, 8'h00);
    settle();
    check(32'(alert_interrupt_n), 32'h1);
    // Fan one failure, masked: flag only
    @(posedge ref_clk);
    fan_unreachable <= 2'h1;
    settle();
    check(32'(alert_interrupt_n), 32'h1);
    rd(A_ST, 8'h40);
    fan_unreachable <= 2'h0;
    settle();
    rd(A_ST, 8'h40);
    rd(A_ST, 8'h00);
    // Disabled drivers hide everything
    fan_unreachable <= 2'h3;
    voltage_match <= 2'h3;
    low_supply_on <= 2'h3;
    wr(A_CT, 8'h80);
    settle();
    rd(A_ST, 8'h00);
    // Short on driver one: voltage-good drops, short flag raised
    fan_unreachable <= 2'h0;
    wr(A_CT, 8'h83);
    wr(A_MK, 8'h03);
    output_short <= 2'h1;
    settle();
    rd(A_ST, 8'h0D);
    rd(A_SH, 8'h01);
    @(negedge ref_clk);
    check(32'(alert_interrupt_n), 32'h0);
    @(posedge ref_clk);
    output_short <= 2'h0;
    settle();
    wr(A_SH, 8'h01);
    settle();
    rd(A_SH, 8'h00);
    @(negedge ref_clk);
    check(32'(alert_interrupt_n), 32'h1);
    rnd_ce = 1'b0;
    settle();
    check(32'(exp_q.size()), 32'h0);
    wrap_up();
  end

endmodule

`default_nettype wire
